// File: core/efuse_fault_status_logic.sv
// Fault supervision, switch control and status pins of the protection switch
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps

module efuse_fault_status_logic #(
  parameter logic [efuse_pkg::CNT_W-1:0] RETRY_CYCLES = efuse_pkg::RETRY_CYCLES_DEF,
  parameter logic [efuse_pkg::CNT_W-1:0] BLANK_CYCLES = efuse_pkg::BLANK_CYCLES_DEF,
  parameter logic [efuse_pkg::CNT_W-1:0] PGA_CYCLES = efuse_pkg::PGA_CYCLES_DEF,
  parameter logic [efuse_pkg::CNT_W-1:0] PGD_CYCLES = efuse_pkg::PGD_CYCLES_DEF
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Analog comparator results, asynchronous
  input wire efuse_pkg::comp_type i_comp,
  // Open-drain status pins
  output logic o_fault_flag_n_o,
  output logic o_fault_flag_n_oe_b,
  output logic o_aux_channel_ctrl_o,
  output logic o_aux_channel_ctrl_oe_b,
  output logic o_power_good_out_o,
  output logic o_power_good_out_oe_b,
  // Power stage control
  output logic o_main_switch_on,
  output logic o_current_limit,
  output logic o_blocking_full,
  output efuse_pkg::clamp_type o_clamp_level
);

  localparam logic [efuse_pkg::CNT_W-1:0] ONE = efuse_pkg::CNT_W'(1);

  efuse_pkg::state_type q;
  efuse_pkg::state_type d;

  // Conditions decoded from the filtered levels, the bus strobe and the status word
  logic input_valid;
  logic switch_ok;
  logic retry_go;
  logic oc_event;
  logic pg_rise;
  logic pg_drop;
  logic pg_force;
  logic clear_latch;
  logic bus_take;
  logic [31:0] stat_word;

  function automatic logic [efuse_pkg::CNT_W-1:0] cnt_step(
    input logic [efuse_pkg::CNT_W-1:0] cnt,
    input logic run
  );
    cnt_step = run ? cnt + ONE : '0;
  endfunction

  always_comb begin
    d = q;

    // Three-stage synchroniser; a bit moves once stages two and three agree
    d.s1 = i_comp;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.f = efuse_pkg::comp_type'((q.s2 & ~(q.s2 ^ q.s3)) | (q.f & (q.s2 ^ q.s3)));

    input_valid = !q.f.undervolt_protect && !q.f.rev_polarity
      && !q.f.overvolt_lockout && !q.f.supply_zero;

    // Only these two levels clear a latch; an enable dip above shutdown is ignored
    clear_latch = q.f.supply_zero || !q.f.en_on;

    // Overcurrent blanking shared by limit, open and shorted sense pin
    oc_event = q.f.over_current || q.f.sense_open || q.f.sense_short;
    d.blank_cnt = q.persist ? '0 : cnt_step(q.blank_cnt, oc_event && q.sw_on);
    if (!oc_event) begin
      d.persist = 1'b0;
    end else if (!q.persist && q.blank_cnt == BLANK_CYCLES - ONE) begin
      d.persist = 1'b1;
    end

    // Thermal shutdown holds until the die cools past hysteresis
    if (q.f.thermal_trip) begin
      d.therm_hold = 1'b1;
    end else if (q.f.thermal_cool) begin
      d.therm_hold = 1'b0;
    end

    // Auto-retry timer runs only once cooled and while still enabled
    retry_go = q.latched && q.cfg.auto_retry && !q.therm_hold && !q.f.thermal_trip
      && q.f.en_on && !q.f.supply_zero;
    d.retry_cnt = cnt_step(q.retry_cnt, retry_go);

    // Latching faults; a new fault wins over an expiring retry
    if (clear_latch) begin
      d.latched = 1'b0;
      d.retry_cnt = '0;
    end else if (retry_go && q.retry_cnt == RETRY_CYCLES - ONE) begin
      d.latched = 1'b0;
      d.retry_cnt = '0;
    end
    if (q.f.thermal_trip
        || (q.persist && q.f.over_current && q.cfg.breaker)
        || (q.persist && q.f.sense_short)) begin
      d.latched = 1'b1;
    end

    // Fast trip on short: switch off, wait, then come back current limited
    if (q.ft_wait) begin
      d.ft_cnt = q.ft_cnt + ONE;
      if (q.ft_cnt == efuse_pkg::FT_CYCLES - ONE) begin
        d.ft_wait = 1'b0;
        d.ft_cnt = '0;
        d.climit = 1'b1;
      end
    end else if (q.f.short_trip && q.sw_on) begin
      d.ft_wait = 1'b1;
      d.ft_cnt = '0;
    end else if (!q.f.over_current && !q.f.short_trip) begin
      d.climit = 1'b0;
    end
    if (q.persist && q.f.over_current && !q.cfg.breaker) begin
      d.climit = 1'b1;
    end

    // Reverse blocking releases only past the forward recovery level
    if (q.f.reverse_trip) begin
      d.rev_block = 1'b1;
    end else if (q.f.forward_recover) begin
      d.rev_block = 1'b0;
    end

    // Main switch; thermal trip acts in the same cycle it is seen
    switch_ok = q.f.en_run && q.f.en_on && input_valid && !q.latched && !q.therm_hold
      && !q.f.thermal_trip && !q.ft_wait && !(q.persist && q.f.sense_open);
    d.sw_on = switch_ok;

    // Fault flag: short circuit, undervolt and overvolt never reach it
    d.flag = q.therm_hold || q.f.thermal_trip || q.latched || q.rev_block
      || (q.persist && oc_event);
    if (clear_latch && !q.therm_hold && !q.rev_block && !q.f.thermal_trip) begin
      d.flag = 1'b0;
    end

    // Aux output set at end of inrush, dropped only by an invalid input
    if (!input_valid) begin
      d.aux = 1'b0;
    end else if (q.f.gate_full && q.sw_on) begin
      d.aux = 1'b1;
    end

    // Power good with separate assert and deassert deglitch
    pg_force = q.f.undervolt_protect || q.f.rev_polarity || q.therm_hold
      || q.f.thermal_trip || (q.latched && q.cfg.breaker);
    pg_drop = q.f.good_below_fall || q.f.overvolt_lockout || q.f.sense_open
      || q.f.sense_short || q.rev_block;
    pg_rise = q.f.gate_full && q.f.good_above_rise && !pg_drop && !pg_force;
    if (pg_force) begin
      d.pg = 1'b0;
      d.pg_cnt = '0;
    end else if (!q.pg) begin
      d.pg_cnt = cnt_step(q.pg_cnt, pg_rise);
      if (pg_rise && q.pg_cnt == PGA_CYCLES - ONE) begin
        d.pg = 1'b1;
        d.pg_cnt = '0;
      end
    end else begin
      d.pg_cnt = cnt_step(q.pg_cnt, pg_drop);
      if (pg_drop && q.pg_cnt == PGD_CYCLES - ONE) begin
        d.pg = 1'b0;
        d.pg_cnt = '0;
      end
    end

    // Strap is caught once, after the synchroniser has settled
    if (!q.strap_done) begin
      d.strap_cnt = q.strap_cnt + 3'h1;
      if (q.strap_cnt == efuse_pkg::STRAP_SETTLE) begin
        d.strap_done = 1'b1;
        if (q.f.strap_low) begin
          d.clamp = efuse_pkg::CLAMP_3V8;
        end else if (q.f.strap_res) begin
          d.clamp = efuse_pkg::CLAMP_13V8;
        end else begin
          d.clamp = efuse_pkg::CLAMP_5V7;
        end
      end
    end

    // Status word
    stat_word = '0;
    stat_word[efuse_pkg::ST_SWITCH_BIT] = q.sw_on;
    stat_word[efuse_pkg::ST_LATCH_BIT] = q.latched;
    stat_word[efuse_pkg::ST_THERM_BIT] = q.therm_hold;
    stat_word[efuse_pkg::ST_FLAG_BIT] = q.flag;
    stat_word[efuse_pkg::ST_AUX_BIT] = q.aux;
    stat_word[efuse_pkg::ST_PG_BIT] = q.pg;
    stat_word[efuse_pkg::ST_CLIM_BIT] = q.climit;
    stat_word[efuse_pkg::ST_REV_BIT] = q.rev_block;
    stat_word[efuse_pkg::ST_CLAMP_LSB +: 2] = q.clamp;
    stat_word[efuse_pkg::ST_FTWAIT_BIT] = q.ft_wait;
    stat_word[efuse_pkg::ST_PERSIST_BIT] = q.persist;

    // AHB-Lite: zero wait states, read data loaded at the address phase
    bus_take = i_hsel && i_htrans[1] && i_hready;
    if (q.hb_wr && q.hb_addr == efuse_pkg::CTRL_OFF) begin
      d.cfg.auto_retry = i_hwdata[efuse_pkg::CTRL_AUTO_BIT];
      d.cfg.breaker = i_hwdata[efuse_pkg::CTRL_BREAKER_BIT];
      d.cfg.pg_variant = i_hwdata[efuse_pkg::CTRL_PGVAR_BIT];
    end
    d.hb_wr = bus_take && i_hwrite;
    d.hb_addr = bus_take ? i_haddr[7:0] : q.hb_addr;
    if (bus_take && !i_hwrite) begin
      if (i_haddr[7:0] == efuse_pkg::CTRL_OFF) begin
        d.hrdata = {29'h0, q.cfg.pg_variant, q.cfg.breaker, q.cfg.auto_retry};
      end else if (i_haddr[7:0] == efuse_pkg::STAT_OFF) begin
        d.hrdata = stat_word;
      end else begin
        d.hrdata = 32'h0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
      q.cfg <= efuse_pkg::cfg_type'(efuse_pkg::CTRL_RESET);
      q.clamp <= efuse_pkg::CLAMP_5V7;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign o_hrdata = q.hrdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_fault_flag_n_o = 1'b0;
  assign o_fault_flag_n_oe_b = !(q.flag && !q.cfg.pg_variant);
  assign o_aux_channel_ctrl_o = 1'b0;
  assign o_aux_channel_ctrl_oe_b = q.aux;
  assign o_power_good_out_o = 1'b0;
  assign o_power_good_out_oe_b = q.pg;
  assign o_main_switch_on = q.sw_on;
  assign o_current_limit = q.climit;
  assign o_blocking_full = !q.rev_block;
  assign o_clamp_level = q.clamp;

  // Checks
  sequence fast_trip_start_s;
    q.f.short_trip && q.sw_on && !q.ft_wait && !q.latched && !q.f.thermal_trip && !q.persist;
  endsequence

  sequence fast_trip_end_s;
    q.ft_wait && q.ft_cnt == efuse_pkg::FT_CYCLES - ONE;
  endsequence

  thermal_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.f.thermal_trip |=> !q.sw_on ##1 !q.sw_on)
    else $error("switch on during thermal trip");

  thermal_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.therm_hold && !q.f.thermal_cool |=> q.therm_hold && !q.sw_on)
    else $error("thermal hold released before cooling");

  latch_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.latched && !q.cfg.auto_retry && q.f.en_on && !q.f.supply_zero |=> q.latched)
    else $error("latch-off fault cleared without toggle");

  latch_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.latched && !q.f.en_on && !q.f.thermal_trip && !q.persist
      |=> !q.latched && q.retry_cnt == '0)
    else $error("latched fault not cleared by enable low");

  retry_expire_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    retry_go && q.retry_cnt == RETRY_CYCLES - ONE && !q.f.thermal_trip && !q.persist
      |=> !q.latched ##1 (!q.flag || $past(q.therm_hold || q.f.thermal_trip || q.rev_block
      || q.persist)))
    else $error("auto retry did not restart");

  fast_trip_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    fast_trip_start_s |=> q.ft_wait && !q.latched ##1 !q.sw_on)
    else $error("fast trip did not open switch");

  trip_resume_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    fast_trip_end_s |=> !q.ft_wait && q.climit)
    else $error("fast trip wait not ended in current limit");

  blank_time_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(q.persist) |-> $past(q.blank_cnt) == BLANK_CYCLES - ONE)
    else $error("blanking interval wrong");

  aux_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.aux && input_valid |=> q.aux)
    else $error("aux dropped with valid input");

  aux_inrush_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !q.aux && !(q.f.gate_full && q.sw_on) |=> !q.aux)
    else $error("aux rose before end of inrush");

  pg_assert_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !q.pg && !(pg_rise && q.pg_cnt == PGA_CYCLES - ONE) |=> !q.pg)
    else $error("power good rose early");

  pg_force_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.f.undervolt_protect || q.therm_hold |=> !q.pg)
    else $error("power good not forced low");

  rev_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.rev_block && !q.f.forward_recover |=> q.rev_block)
    else $error("reverse block released early");

  thermal_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.f.thermal_trip |=> q.flag)
    else $error("fault flag not set by thermal trip");

  short_no_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.ft_wait && !q.therm_hold && !q.f.thermal_trip && !q.latched && !q.rev_block && !q.persist
      |=> !q.flag && !q.latched)
    else $error("output short latched or raised the flag");

  breaker_latch_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.persist && q.f.over_current && q.cfg.breaker |=> q.latched)
    else $error("breaker overload not latched");

  retry_wait_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.latched && q.retry_cnt != RETRY_CYCLES - ONE && q.f.en_on && !q.f.supply_zero |=> q.latched)
    else $error("latch released before retry delay");

  ft_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.ft_wait && q.ft_cnt != efuse_pkg::FT_CYCLES - ONE |=> q.ft_wait && !q.sw_on)
    else $error("fast trip wait ended early");

  rev_enter_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.f.reverse_trip |=> q.rev_block)
    else $error("reverse trip not blocked");

  aux_invalid_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !input_valid |=> !q.aux)
    else $error("aux high with invalid input");

  pg_glitch_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.pg && !pg_force && q.pg_cnt != PGD_CYCLES - ONE |=> q.pg)
    else $error("power good dropped before deglitch");

  strap_decode_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !q.strap_done && q.strap_cnt == efuse_pkg::STRAP_SETTLE && q.f.strap_low
      |=> q.clamp == efuse_pkg::CLAMP_3V8)
    else $error("grounded strap not decoded");

  clamp_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    q.strap_done |=> $stable(q.clamp))
    else $error("clamp level changed after capture");

endmodule

// File: include/efuse_pkg.sv
// Constants, carriers and state layout of the eFuse fault and status logic
package efuse_pkg;

  // Counter width shared by every timer but the 3-bit strap settle counter
  localparam int CNT_W = 24;

  // AHB-Lite register map
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;

  // Control register fields and reset
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_BREAKER_BIT = 1;
  localparam int CTRL_PGVAR_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Status register fields
  localparam int ST_SWITCH_BIT = 0;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_THERM_BIT = 2;
  localparam int ST_FLAG_BIT = 3;
  localparam int ST_AUX_BIT = 4;
  localparam int ST_PG_BIT = 5;
  localparam int ST_CLIM_BIT = 6;
  localparam int ST_REV_BIT = 7;
  localparam int ST_CLAMP_LSB = 8;
  localparam int ST_FTWAIT_BIT = 10;
  localparam int ST_PERSIST_BIT = 11;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FAST_TRIP_WAIT_NS = 30000;
  localparam logic [CNT_W-1:0] FT_CYCLES =
    CNT_W'((FAST_TRIP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RETRY_CYCLES_DEF = 24'h00c350;
  localparam logic [CNT_W-1:0] BLANK_CYCLES_DEF = 24'h004e20;
  localparam logic [CNT_W-1:0] PGA_CYCLES_DEF = 24'h000400;
  localparam logic [CNT_W-1:0] PGD_CYCLES_DEF = 24'h000040;
  localparam logic [2:0] STRAP_SETTLE = 3'h4;

  typedef enum logic [1:0] {
    CLAMP_3V8 = 2'b00,
    CLAMP_5V7 = 2'b01,
    CLAMP_13V8 = 2'b10
  } clamp_type;

  // Digitised comparator results, all active high
  typedef struct packed {
    logic thermal_trip;
    logic thermal_cool;
    logic en_on;
    logic en_run;
    logic supply_zero;
    logic undervolt_protect;
    logic rev_polarity;
    logic overvolt_lockout;
    logic overvolt_clamp;
    logic over_current;
    logic short_trip;
    logic sense_open;
    logic sense_short;
    logic reverse_trip;
    logic forward_recover;
    logic gate_full;
    logic good_above_rise;
    logic good_below_fall;
    logic strap_low;
    logic strap_res;
  } comp_type;

  typedef struct packed {
    logic pg_variant;
    logic breaker;
    logic auto_retry;
  } cfg_type;

  typedef struct packed {
    comp_type s1;
    comp_type s2;
    comp_type s3;
    comp_type f;
    cfg_type cfg;
    logic sw_on;
    logic latched;
    logic therm_hold;
    logic [CNT_W-1:0] retry_cnt;
    logic [CNT_W-1:0] blank_cnt;
    logic persist;
    logic [CNT_W-1:0] ft_cnt;
    logic ft_wait;
    logic climit;
    logic rev_block;
    logic aux;
    logic pg;
    logic [CNT_W-1:0] pg_cnt;
    logic flag;
    logic [2:0] strap_cnt;
    logic strap_done;
    clamp_type clamp;
    logic [7:0] hb_addr;
    logic hb_wr;
    logic [31:0] hrdata;
  } state_type;

endpackage

// File: sim/efuse_far_side.sv
// Board side of the status pins: pull-ups and the levels a supervisor sees
`timescale 1ns/1ps
module efuse_far_side (
  // Pin drivers from the block
  input wire logic i_flag_o,
  input wire logic i_flag_oe_b,
  input wire logic i_aux_o,
  input wire logic i_aux_oe_b,
  input wire logic i_pg_o,
  input wire logic i_pg_oe_b,
  // Resolved board levels
  output logic o_flag_pin,
  output logic o_aux_pin,
  output logic o_pg_pin
);
  // Released pin goes to the pull-up level, never a stale driven value
  assign o_flag_pin = i_flag_oe_b ? 1'b1 : i_flag_o;
  assign o_aux_pin = i_aux_oe_b ? 1'b1 : i_aux_o;
  assign o_pg_pin = i_pg_oe_b ? 1'b1 : i_pg_o;
endmodule

// File: sim/testbench.sv
// Self-checking bench for the eFuse fault and status logic
`timescale 1ns/1ps
module testbench;
  // Short counts keep the run brief
  localparam logic [efuse_pkg::CNT_W-1:0] RETRY_C = 24'h000010;
  localparam logic [efuse_pkg::CNT_W-1:0] BLANK_C = 24'h00000c;
  localparam logic [efuse_pkg::CNT_W-1:0] PGA_C = 24'h00000a;
  localparam logic [efuse_pkg::CNT_W-1:0] PGD_C = 24'h000008;
  localparam int PGA = 10;
  localparam int PGD = 8;
  logic i_core_clk;
  logic i_rst_b;
  logic hsel;
  logic hwrite;
  logic hready;
  logic hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  efuse_pkg::comp_type comp;
  efuse_pkg::clamp_type clamp;
  efuse_pkg::clamp_type cl_exp [3];
  logic flag_o, flag_oe_b, aux_o, aux_oe_b, pg_o, pg_oe_b;
  logic sw_on, climit, blk_full, flag_pin, aux_pin, pg_pin;
  logic [4:0] obs;
  int num_errors;
  int checks_done;
  assign obs = {blk_full, pg_pin, aux_pin, flag_pin, sw_on};

  efuse_fault_status_logic #(.RETRY_CYCLES(RETRY_C), .BLANK_CYCLES(BLANK_C),
    .PGA_CYCLES(PGA_C), .PGD_CYCLES(PGD_C)) i_efuse_fault_status_logic (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_comp(comp), .o_fault_flag_n_o(flag_o), .o_fault_flag_n_oe_b(flag_oe_b),
    .o_aux_channel_ctrl_o(aux_o), .o_aux_channel_ctrl_oe_b(aux_oe_b),
    .o_power_good_out_o(pg_o), .o_power_good_out_oe_b(pg_oe_b),
    .o_main_switch_on(sw_on), .o_current_limit(climit), .o_blocking_full(blk_full),
    .o_clamp_level(clamp));

  efuse_far_side i_efuse_far_side (
    .i_flag_o(flag_o), .i_flag_oe_b(flag_oe_b), .i_aux_o(aux_o), .i_aux_oe_b(aux_oe_b),
    .i_pg_o(pg_o), .i_pg_oe_b(pg_oe_b), .o_flag_pin(flag_pin), .o_aux_pin(aux_pin),
    .o_pg_pin(pg_pin));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic tick(input int c);
    repeat (c) @(posedge i_core_clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits for one observed pin and checks how many cycles it took
  task automatic wait_obs(input int s, input logic v, input int lo, input int hi,
    input string nm);
    int c;
    c = 0;
    while (obs[s] !== v && c <= hi) begin
      @(posedge i_core_clk);
      c++;
    end
    checks_done++;
    if (c < lo || c > hi) begin
      num_errors++;
      $display("[ERR] %s expected %0d..%0d cycles seen %0d", nm, lo, hi, c);
    end
  endtask

  // Single AHB-Lite word transfer; read data taken at the data phase edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge i_core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge i_core_clk);
    while (hready !== 1'b1) @(posedge i_core_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge i_core_clk);
    while (hready !== 1'b1) @(posedge i_core_clk);
    r = hrdata;
  endtask

  task automatic latch_bit(input logic e);
    ahb(1'b0, efuse_pkg::STAT_OFF, 32'h0, rd);
    chk("latched", {31'h0, e}, {31'h0, rd[efuse_pkg::ST_LATCH_BIT]});
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    i_rst_b = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    comp = '0;
    num_errors = 0;
    checks_done = 0;
    cl_exp = '{efuse_pkg::CLAMP_3V8, efuse_pkg::CLAMP_5V7, efuse_pkg::CLAMP_13V8};
    // Strap is captured once after reset, so each code needs its own reset
    for (int k = 0; k < 3; k++) begin
      comp.strap_low <= (k == 0);
      comp.strap_res <= (k == 2);
      i_rst_b <= 1'b0;
      tick(6);
      i_rst_b <= 1'b1;
      tick(8);
      chk("clamp", 32'(cl_exp[k]), 32'(clamp));
    end
    chk("reset pins", 32'h12, 32'(obs));
    chk("hresp", 32'h0, 32'(hresp));
    ahb(1'b0, efuse_pkg::CTRL_OFF, 32'h0, rd);
    chk("ctrl reset", 32'(efuse_pkg::CTRL_RESET), rd);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, efuse_pkg::CTRL_OFF, 32'h7, rd);
    ahb(1'b0, efuse_pkg::CTRL_OFF, 32'h0, rd);
    chk("ctrl rw", 32'h7, rd);
    ahb(1'b1, efuse_pkg::CTRL_OFF, 32'h0, rd);
    // Power up: aux waits for full gate drive, pg for the assert deglitch
    comp.en_on <= 1'b1;
    comp.en_run <= 1'b1;
    comp.good_above_rise <= 1'b1;
    tick(20);
    chk("aux in inrush", 32'h0, 32'(aux_pin));
    comp.gate_full <= 1'b1;
    wait_obs(2, 1'b1, 3, 8, "aux rise");
    wait_obs(3, 1'b1, PGA - 3, PGA + 8, "pg rise");
    // Persistent limit: flag after blanking, no latch, pg and aux untouched
    comp.over_current <= 1'b1;
    wait_obs(1, 1'b0, 12, 22, "flag after blank");
    chk("pg in limit", 32'h1, 32'(pg_pin));
    chk("aux in limit", 32'h1, 32'(aux_pin));
    chk("limit on", 32'h1, 32'(climit));
    latch_bit(1'b0);
    comp.over_current <= 1'b0;
    wait_obs(1, 1'b1, 0, 8, "flag release");
    // Breaker latch, enable dip ignored, enable toggle clears
    ahb(1'b1, efuse_pkg::CTRL_OFF, 32'h2, rd);
    comp.over_current <= 1'b1;
    wait_obs(0, 1'b0, 12, 22, "breaker off");
    wait_obs(3, 1'b0, 0, 4, "pg breaker");
    comp.over_current <= 1'b0;
    comp.en_run <= 1'b0;
    tick(20);
    latch_bit(1'b1);
    comp.en_on <= 1'b0;
    tick(10);
    latch_bit(1'b0);
    chk("flag cleared", 32'h1, 32'(flag_pin));
    comp.en_on <= 1'b1;
    comp.en_run <= 1'b1;
    wait_obs(0, 1'b1, 0, 20, "on after clear");
    // Thermal, latch-off variant
    ahb(1'b1, efuse_pkg::CTRL_OFF, 32'h0, rd);
    comp.thermal_trip <= 1'b1;
    wait_obs(0, 1'b0, 3, 6, "thermal off");
    wait_obs(1, 1'b0, 0, 2, "thermal flag");
    wait_obs(3, 1'b0, 0, 4, "thermal pg");
    chk("aux thermal", 32'h1, 32'(aux_pin));
    comp.thermal_trip <= 1'b0;
    tick(30);
    chk("hot hold", 32'h0, 32'(sw_on));
    comp.thermal_cool <= 1'b1;
    tick(40);
    chk("latched off", 32'h0, 32'(sw_on));
    comp.en_on <= 1'b0;
    tick(10);
    comp.en_on <= 1'b1;
    wait_obs(0, 1'b1, 0, 20, "re-enabled");
    // Thermal, auto-retry variant
    ahb(1'b1, efuse_pkg::CTRL_OFF, 32'h1, rd);
    comp.thermal_trip <= 1'b1;
    comp.thermal_cool <= 1'b0;
    wait_obs(0, 1'b0, 3, 6, "retry trip");
    comp.thermal_trip <= 1'b0;
    tick(40);
    chk("retry hot", 32'h0, 32'(sw_on));
    comp.thermal_cool <= 1'b1;
    wait_obs(0, 1'b1, 16, 26, "retry delay");
    wait_obs(1, 1'b1, 0, 4, "retry flag");
    // Output short: fast trip, wait, restart, no latch, no flag
    ahb(1'b1, efuse_pkg::CTRL_OFF, 32'h0, rd);
    comp.short_trip <= 1'b1;
    wait_obs(0, 1'b0, 3, 8, "short off");
    chk("short flag", 32'h1, 32'(flag_pin));
    tick(5);
    comp.short_trip <= 1'b0;
    wait_obs(0, 1'b1, 2950, 3010, "short restart");
    latch_bit(1'b0);
    // Reverse current blocks until the forward drop recovers
    comp.reverse_trip <= 1'b1;
    wait_obs(4, 1'b0, 3, 8, "reverse block");
    wait_obs(1, 1'b0, 0, 4, "reverse flag");
    wait_obs(3, 1'b0, PGD - 6, PGD + 8, "reverse pg");
    comp.reverse_trip <= 1'b0;
    tick(20);
    chk("still blocked", 32'h0, 32'(blk_full));
    // Power-good variant leaves the flag pin released
    ahb(1'b1, efuse_pkg::CTRL_OFF, 32'h4, rd);
    tick(1);
    chk("flag variant", 32'h1, 32'(flag_pin));
    ahb(1'b1, efuse_pkg::CTRL_OFF, 32'h0, rd);
    comp.forward_recover <= 1'b1;
    wait_obs(4, 1'b1, 3, 8, "forward recover");
    wait_obs(3, 1'b1, 0, PGA + 20, "pg back");
    // Undervoltage drops aux and pg, leaves flag released
    comp.undervolt_protect <= 1'b1;
    wait_obs(2, 1'b0, 3, 8, "uv aux");
    wait_obs(3, 1'b0, 0, 4, "uv pg");
    chk("uv flag", 32'h1, 32'(flag_pin));
    comp.undervolt_protect <= 1'b0;
    wait_obs(2, 1'b1, 0, 20, "aux back");
    // Shorted sense pin latches after blanking
    comp.sense_short <= 1'b1;
    wait_obs(0, 1'b0, 12, 22, "sense short off");
    chk("sense short flag", 32'h0, 32'(flag_pin));
    comp.sense_short <= 1'b0;
    tick(10);
    latch_bit(1'b1);
    tally_and_finish();
  end
endmodule
